// ---- design/sas_pkg.sv ----
// Purpose: Shared constants for the scan address sequencer block
// Assumes: One scan clock; sequencer values are plain binary
// Notes:   Storage address is 24 bits, bit 0 is the most significant
package sas_pkg;
    localparam int SEQ_W       = 5;
    localparam int CST_W       = 3;
    localparam int FLT_W       = 4;
    localparam int ADDR_W      = 24;
    localparam int WORDS       = 24;
    // Preset values for the address sequencer
    localparam logic [4:0] SEQ_LOGOUT_TOP = 5'h17; // 23
    localparam logic [4:0] SEQ_HOLD_LAST  = 5'h0e; // 14
    localparam logic [4:0] SEQ_RUN_FROM   = 5'h0d; // 13
    localparam logic [4:0] SEQ_SCANIN_TOP = 5'h10; // 16
    localparam logic [4:0] SEQ_SEVEN      = 5'h07;
    localparam logic [4:0] SEQ_FIFTEEN    = 5'h0f;
    localparam logic [4:0] SEQ_ONE        = 5'h01;
    localparam logic [4:0] SEQ_ZERO       = 5'h00;
    // Control-store test sequencer values
    localparam logic [2:0] CST_START      = 3'h7;
    localparam logic [2:0] CST_SYNC_A     = 3'h1;
    localparam logic [2:0] CST_SYNC_B     = 3'h3;
    localparam logic [2:0] CST_SYNC_C     = 3'h6;
    // Field positions, counted from the low end of a [23:0] vector
    localparam int SAB_BIT14   = 9;  // Address bit 14
    localparam int SAB_BIT15   = 8;  // Address bit 15
    localparam int SAB_SEQ_LO  = 3;  // Address bit 20
    localparam int SAB_SEQ_HI  = 7;  // Address bit 16
    // Microprogram preset orders
    typedef enum logic [2:0] {
        SAS_SET_NONE, SAS_SET_7, SAS_SET_13, SAS_SET_15, SAS_SET_16, SAS_SET_23
    } sas_preset_e;
    // Scan operation modes
    typedef enum logic [2:0] {
        SAS_MODE_IDLE, SAS_MODE_LOGIC_TEST, SAS_MODE_CS_TEST, SAS_MODE_LOGOUT,
        SAS_MODE_COUNT
    } sas_mode_e;
endpackage : sas_pkg

// ---- design/sas_decrementer.sv ----
// Purpose: Shared holding latch and minus-one network
// Assumes: Source select is one-hot or zero
// Notes:   Latch captures on the capture strobe; result is combinational
`timescale 1ns/1ps
module sas_decrementer
    import sas_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // Capture side
    input  wire logic             capture,
    input  wire logic [SEQ_W-1:0] capture_val,
    // Result side
    output logic      [SEQ_W-1:0] result
);
    logic [SEQ_W-1:0] adder_input_latch;

    // Holding latch loaded from the chosen source
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            adder_input_latch <= SEQ_ZERO;
        end else if (capture) begin
            adder_input_latch <= capture_val;
        end
    end

    // Minus-one network
    assign result = adder_input_latch - SEQ_ONE;
endmodule : sas_decrementer

// ---- design/sas_word_decoder.sv ----
// Purpose: Split decode of the address sequencer into word selects
// Assumes: Values 0 to 23 select a word; others select none
// Notes:   High two bits and low three bits decoded apart, then combined
`timescale 1ns/1ps
module sas_word_decoder
    import sas_pkg::*;
(
    // Sequencer value and enable
    input  wire logic             enable,
    input  wire logic [SEQ_W-1:0] seq,
    // One-hot word selects
    output logic      [WORDS-1:0] word_sel
);
    logic [3:0] hi_dec;
    logic [7:0] lo_dec;

    // Partial decodes
    assign hi_dec = enable ? (4'h1 << seq[4:3]) : 4'h0;
    assign lo_dec = 8'h01 << seq[2:0];

    // Combine partial decodes
    genvar h;
    generate
        for (h = 0; h < 3; h++) begin : g_grp
            assign word_sel[h*8 +: 8] = hi_dec[h] ? lo_dec : 8'h00;
        end
    endgenerate
endmodule : sas_word_decoder

// ---- design/sas_sequencer.sv ----
// Purpose: Scan counting and storage addressing unit
// Assumes: Capture phase and write-back phase are two core_clk cycles
// Notes:   A decrement takes a capture cycle then a write-back cycle
//
// How it works
// RULE1: one counter uses decrement path per cycle
// RULE2: decrement via holding latch and minus-one network
// RULE3: capture and clear source, write back next
// RULE4: sequencer loads from word, hardware, presets
// RULE5: scan-out decodes one of 24 selects
// RULE6: sequencer is top five bits in count mode
// RULE7: scan-in starts at 16, zero means done
// RULE8: word at count one reloads sequencer
// RULE9: logout from 23, clock held 23 to 14
// RULE10: first logout zero forces 23, then 7
// RULE11: decoder combines high and low partial decodes
// RULE12: logout area spans hex 80 to 138
// RULE13: tests alternate between two buffers
// RULE14: address bits 0-13, 21-23 zero
// RULE15: logout bit 16 is inverse sequencer bit 0
// RULE16: buffer flag forces address bit 15 or 14
// RULE17: buffer flag toggles on seven or order
// RULE18: address gated only while scan-sync set
// RULE19: test sequencer starts at 7, steps at phase 3
// RULE20: fixed priority among decrement requests
`timescale 1ns/1ps
module sas_sequencer
    import sas_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // Mode and timing
    input  wire sas_mode_e         mode,
    input  wire logic [1:0]        flt_phase,
    // Sequencer loading
    input  wire logic [SEQ_W-1:0]  work_reg_bits,
    input  wire logic              load_from_word,
    input  wire sas_preset_e       preset_order,
    input  wire logic              cs_test_start,
    input  wire logic              left_word_select,
    // Decrement requests
    input  wire logic              seq_dec_req,
    input  wire logic              flt_dec_req,
    input  wire logic [FLT_W-1:0]  flt_load_val,
    input  wire logic              flt_load,
    // Micro-orders
    input  wire logic              toggle_buffer_order,
    input  wire logic              scan_store_order,
    input  wire logic              scan_sync_clear,
    input  wire logic              scan_out_active,
    // Status and outputs
    output logic [SEQ_W-1:0]       seq_value,
    output logic [FLT_W-1:0]       flt_value,
    output logic [CST_W-1:0]       cs_seq_value,
    output logic                   buffer_one,
    output logic                   scan_sync,
    output logic                   cpu_clock_hold,
    output logic                   scan_in_done,
    output logic                   logout_done,
    output logic                   control_word_fetch,
    output logic                   scan_left_word,
    output logic [WORDS-1:0]       word_sel,
    output logic [ADDR_W-1:0]      storage_address_bus,
    output logic                   dec_busy
);
    // Source selection for the shared path
    typedef enum logic [1:0] {SAS_SRC_NONE, SAS_SRC_SEQ, SAS_SRC_FLT, SAS_SRC_CST} sas_src_e;

    sas_src_e          src;
    sas_src_e          next_src;
    logic [SEQ_W-1:0]  dec_result;
    logic [SEQ_W-1:0]  capture_val;
    logic              capture;
    logic              write_back;
    logic              seq_pend;
    logic              flt_pend;
    logic              cst_pend;
    logic              logout_second;
    logic              cs_toggled;
    logic [SEQ_W-1:0]  preset_val;
    logic              preset_hit;
    logic              count_mode;
    logic [ADDR_W-1:0] next_addr;
    logic [SEQ_W-1:0]  seq_eff;

    // Fixed priority grant: test sequencer, cycle counter, address sequencer
    assign next_src = (src != SAS_SRC_NONE) ? SAS_SRC_NONE :        // [RULE1]
                      cst_pend ? SAS_SRC_CST :                     // [RULE20]
                      flt_pend ? SAS_SRC_FLT :
                      seq_pend ? SAS_SRC_SEQ : SAS_SRC_NONE;
    assign capture    = (src == SAS_SRC_NONE) && (next_src != SAS_SRC_NONE);
    assign write_back = (src != SAS_SRC_NONE);
    assign dec_busy   = write_back;
    assign capture_val = (next_src == SAS_SRC_CST) ? {2'b00, cs_seq_value} :
                         (next_src == SAS_SRC_FLT) ? {1'b0, flt_value} :
                         seq_value;                                // [RULE2]
    assign count_mode = (mode == SAS_MODE_COUNT);

    // Value in flight, so the clock hold never sees the cleared zero
    assign seq_eff = (write_back && src == SAS_SRC_SEQ) ? dec_result : seq_value;

    // Preset decode of microprogram orders
    assign preset_val = (preset_order == SAS_SET_7)  ? SEQ_SEVEN :
                        (preset_order == SAS_SET_13) ? SEQ_RUN_FROM :
                        (preset_order == SAS_SET_15) ? SEQ_FIFTEEN :
                        (preset_order == SAS_SET_16) ? SEQ_SCANIN_TOP :
                        SEQ_LOGOUT_TOP;
    assign preset_hit = (preset_order != SAS_SET_NONE);

    sas_decrementer u_dec (
        .core_clk    (core_clk),
        .arst_n      (arst_n),
        .capture     (capture),
        .capture_val (capture_val),
        .result      (dec_result)
    );

    // Grant state
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) src <= SAS_SRC_NONE;
        else         src <= next_src;
    end

    // Pending requests, set wins over service
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_pend <= 1'b0;
            flt_pend <= 1'b0;
            cst_pend <= 1'b0;
        end else begin
            seq_pend <= (seq_dec_req || (count_mode && flt_dec_req && flt_value == '0))
                        || (seq_pend && !(capture && next_src == SAS_SRC_SEQ));
            flt_pend <= (flt_dec_req && !(count_mode && flt_value == '0))
                        || (flt_pend && !(capture && next_src == SAS_SRC_FLT));
            cst_pend <= (mode == SAS_MODE_CS_TEST && flt_phase == 2'd3)   // [RULE19]
                        || (cst_pend && !(capture && next_src == SAS_SRC_CST));
        end
    end

    // Address sequencer register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_value <= SEQ_ZERO;
        end else if (mode == SAS_MODE_LOGOUT && write_back && src == SAS_SRC_SEQ
                     && dec_result == SEQ_ZERO && !logout_second) begin
            seq_value <= SEQ_LOGOUT_TOP;                           // [RULE10]
        end else if (write_back && src == SAS_SRC_SEQ) begin
            seq_value <= dec_result;                               // [RULE3]
        end else if (capture && next_src == SAS_SRC_SEQ) begin
            seq_value <= SEQ_ZERO;                                 // [RULE3]
        end else if (load_from_word) begin
            seq_value <= work_reg_bits;                            // [RULE4] [RULE8]
        end else if (preset_hit) begin
            seq_value <= preset_val;                               // [RULE4] [RULE7] [RULE9]
        end
    end

    // Cycle counter low part; wraps to all ones when sequencer takes the borrow
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flt_value <= '0;
        end else if (write_back && src == SAS_SRC_FLT) begin
            flt_value <= dec_result[FLT_W-1:0];
        end else if (capture && next_src == SAS_SRC_FLT) begin
            flt_value <= '0;
        end else if (flt_load) begin
            flt_value <= flt_load_val;
        end else if (write_back && src == SAS_SRC_SEQ && count_mode) begin
            flt_value <= '1;                                       // [RULE6]
        end
    end

    // Control-store test sequencer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_seq_value <= CST_START;
        end else if (cs_test_start) begin
            cs_seq_value <= CST_START;                             // [RULE19]
        end else if (write_back && src == SAS_SRC_CST) begin
            cs_seq_value <= dec_result[CST_W-1:0];
        end else if (capture && next_src == SAS_SRC_CST) begin
            cs_seq_value <= '0;
        end
    end

    // Logout second pass marker
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            logout_second <= 1'b0;
        end else if (mode != SAS_MODE_LOGOUT) begin
            logout_second <= 1'b0;
        end else if (write_back && src == SAS_SRC_SEQ && dec_result == SEQ_ZERO) begin
            logout_second <= 1'b1;                                 // [RULE10]
        end
    end

    // Buffer select flag; toggles once per visit to seven in CS test mode, and on the toggle order in logic test mode
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            buffer_one <= 1'b1;
            cs_toggled <= 1'b0;
        end else begin
            cs_toggled <= (mode == SAS_MODE_CS_TEST && cs_seq_value == CST_START);
            if ((mode == SAS_MODE_CS_TEST && cs_seq_value == CST_START && !cs_toggled)
                || (mode == SAS_MODE_LOGIC_TEST && toggle_buffer_order)) begin
                buffer_one <= !buffer_one;                         // [RULE13] [RULE17]
            end
        end
    end

    // Scan-sync flag, set wins over clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scan_sync <= 1'b0;
        end else if (((mode == SAS_MODE_LOGIC_TEST || mode == SAS_MODE_LOGOUT)
                      && scan_store_order)
                     || (mode == SAS_MODE_CS_TEST && (cs_seq_value == CST_SYNC_A
                         || cs_seq_value == CST_SYNC_B || cs_seq_value == CST_SYNC_C))) begin
            scan_sync <= 1'b1;                                     // [RULE18]
        end else if (scan_sync_clear) begin
            scan_sync <= 1'b0;
        end
    end

    // Storage address generator
    always_comb begin
        next_addr = '0;                                            // [RULE14]
        next_addr[SAB_SEQ_HI:SAB_SEQ_LO] = seq_value;              // [RULE14]
        if (mode == SAS_MODE_LOGOUT) begin
            next_addr[SAB_BIT15]  = seq_value[SEQ_W-1];            // [RULE12]
            next_addr[SAB_SEQ_HI] = !seq_value[SEQ_W-1];           // [RULE15]
        end else if (buffer_one) begin
            next_addr[SAB_BIT15] = 1'b1;                           // [RULE16]
        end else begin
            next_addr[SAB_BIT14] = 1'b1;                           // [RULE16]
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) storage_address_bus <= '0;
        else         storage_address_bus <= scan_sync ? next_addr : '0; // [RULE18]
    end

    // Status flags from registered state
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_clock_hold     <= 1'b0;
            scan_in_done       <= 1'b0;
            logout_done        <= 1'b0;
            control_word_fetch <= 1'b0;
            scan_left_word     <= 1'b0;
        end else begin
            cpu_clock_hold     <= (mode == SAS_MODE_LOGOUT) && !logout_second
                                  && seq_eff >= SEQ_HOLD_LAST;     // [RULE9]
            scan_in_done       <= (mode == SAS_MODE_LOGIC_TEST) && seq_value == SEQ_ZERO
                                  && !dec_busy;                    // [RULE7]
            logout_done        <= (mode == SAS_MODE_LOGOUT) && logout_second
                                  && seq_value == SEQ_ZERO && !dec_busy; // [RULE10]
            control_word_fetch <= (mode == SAS_MODE_LOGIC_TEST) && seq_value == SEQ_ONE; // [RULE8]
            if (load_from_word) scan_left_word <= left_word_select; // [RULE8]
        end
    end

    // Word selects, registered
    logic [WORDS-1:0] word_dec;
    sas_word_decoder u_wdec (
        .enable   (scan_out_active),                               // [RULE5]
        .seq      (seq_value),
        .word_sel (word_dec)                                       // [RULE11]
    );
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) word_sel <= '0;
        else         word_sel <= word_dec;
    end

    // Checks
    property p_one_user;
        @(posedge core_clk) disable iff (!arst_n) capture |-> !write_back;
    endproperty
    a_one_user: assert property (p_one_user) else $error("path shared"); // [RULE1]
    property p_dec_seq;
        @(posedge core_clk) disable iff (!arst_n)
        (capture && next_src == SAS_SRC_SEQ && mode != SAS_MODE_LOGOUT && !load_from_word)
        |=> seq_value == '0 ##1 seq_value == $past(seq_value, 2) - SEQ_ONE;
    endproperty
    a_dec_seq: assert property (p_dec_seq) else $error("bad decrement"); // [RULE2] [RULE3]
    property p_onehot;
        @(posedge core_clk) disable iff (!arst_n)
        (scan_out_active && seq_value < SEQ_LOGOUT_TOP + SEQ_ONE) |=> $onehot(word_sel);
    endproperty
    a_onehot: assert property (p_onehot) else $error("select not one-hot"); // [RULE5] [RULE11]
    property p_zero_bits;
        @(posedge core_clk) disable iff (!arst_n)
        storage_address_bus[23:10] == '0 && storage_address_bus[2:0] == '0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("address bits set"); // [RULE14]
    property p_gate;
        @(posedge core_clk) disable iff (!arst_n) !scan_sync |=> storage_address_bus == '0;
    endproperty
    a_gate: assert property (p_gate) else $error("address without sync"); // [RULE18]
    property p_logout_inv;
        @(posedge core_clk) disable iff (!arst_n)
        (scan_sync && mode == SAS_MODE_LOGOUT)
        |=> storage_address_bus[SAB_SEQ_HI] != $past(seq_value[SEQ_W-1]);
    endproperty
    a_logout_inv: assert property (p_logout_inv) else $error("logout bit 16"); // [RULE15]
    property p_buf;
        @(posedge core_clk) disable iff (!arst_n)
        (scan_sync && mode == SAS_MODE_LOGIC_TEST)
        |=> storage_address_bus[SAB_BIT15] == $past(buffer_one)
            && storage_address_bus[SAB_BIT14] == !$past(buffer_one);
    endproperty
    a_buf: assert property (p_buf) else $error("buffer bits"); // [RULE16]
    property p_toggle;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == SAS_MODE_LOGIC_TEST && toggle_buffer_order) |=> buffer_one != $past(buffer_one);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle"); // [RULE17]
    property p_hold;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == SAS_MODE_LOGOUT && !logout_second && seq_value == SEQ_RUN_FROM)
        |=> !cpu_clock_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("clock held at 13"); // [RULE9]
    property p_hold_on;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == SAS_MODE_LOGOUT && !logout_second && seq_value > SEQ_HOLD_LAST
         && !preset_hit && !load_from_word) ##1 (mode == SAS_MODE_LOGOUT) |=> cpu_clock_hold;
    endproperty
    a_hold_on: assert property (p_hold_on) else $error("clock hold dropped"); // [RULE9]
    property p_cst_start;
        @(posedge core_clk) disable iff (!arst_n) cs_test_start |=> cs_seq_value == CST_START;
    endproperty
    a_cst_start: assert property (p_cst_start) else $error("cs start"); // [RULE19]
    c_seq_dec:  cover property (@(posedge core_clk) write_back && src == SAS_SRC_SEQ);
    c_relog:    cover property (@(posedge core_clk) $rose(logout_second));
    c_scanin:   cover property (@(posedge core_clk) $rose(scan_in_done));
    c_conflict: cover property (@(posedge core_clk) seq_pend && flt_pend && cst_pend);
    c_hold:     cover property (@(posedge core_clk) $fell(cpu_clock_hold));
endmodule : sas_sequencer

// ---- verif/sas_storage_model.sv ----
// Purpose: Storage side of the scan address bus
// Assumes: A storage access is one cycle with scan-sync up
// Notes:   Passive; records what the sequencer gates onto the bus
`timescale 1ns/1ps
module sas_storage_model
    import sas_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // Address side
    input  wire logic              scan_sync,
    input  wire logic [ADDR_W-1:0] storage_address_bus,
    // Observed traffic
    output logic      [ADDR_W-1:0] last_addr,
    output logic      [15:0]       access_count
);
    // Record each address gated while scan-sync is up
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_addr    <= 24'h000000;
            access_count <= 16'h0000;
        end else if (scan_sync) begin
            last_addr    <= storage_address_bus;
            access_count <= access_count + 16'h0001;
        end
    end
endmodule : sas_storage_model

// ---- verif/test_scan_address_sequencer.sv ----
// Purpose: Self-checking bench for the scan counting and addressing unit
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes:   Expected values come from a small integer model in the bench
`timescale 1ns/1ps
module test_scan_address_sequencer
    import sas_pkg::*;
;
    logic core_clk = 1'b0, arst_n = 1'b0;
    sas_mode_e mode = SAS_MODE_IDLE;
    sas_preset_e preset_order = SAS_SET_NONE;
    logic [1:0] flt_phase = 2'h0;
    logic [4:0] work_reg_bits = 5'h00;
    logic [3:0] flt_load_val = 4'h0;
    logic load_from_word = 0, cs_test_start = 0, left_word_select = 0, seq_dec_req = 0;
    logic flt_dec_req = 0, flt_load = 0, toggle_buffer_order = 0, scan_store_order = 0;
    logic scan_sync_clear = 0, scan_out_active = 1;
    logic [4:0] seq_value;
    logic [3:0] flt_value;
    logic [2:0] cs_seq_value;
    logic buffer_one, scan_sync, cpu_clock_hold, scan_in_done, logout_done, scan_left_word;
    logic [23:0] word_sel, storage_address_bus, last_addr;
    logic [15:0] access_count;
    logic dec_busy, control_word_fetch;
    int err_total = 0, checked = 0, m_buf, v, lw;
    int pv[$] = '{7, 13, 15, 16, 23};
    sas_preset_e po[$] = '{SAS_SET_7, SAS_SET_13, SAS_SET_15, SAS_SET_16, SAS_SET_23};

    sas_sequencer u_dut (.core_clk(core_clk), .arst_n(arst_n), .mode(mode),
        .flt_phase(flt_phase), .work_reg_bits(work_reg_bits), .load_from_word(load_from_word),
        .preset_order(preset_order), .cs_test_start(cs_test_start),
        .left_word_select(left_word_select), .seq_dec_req(seq_dec_req),
        .flt_dec_req(flt_dec_req), .flt_load_val(flt_load_val), .flt_load(flt_load),
        .toggle_buffer_order(toggle_buffer_order), .scan_store_order(scan_store_order),
        .scan_sync_clear(scan_sync_clear), .scan_out_active(scan_out_active),
        .seq_value(seq_value), .flt_value(flt_value), .cs_seq_value(cs_seq_value),
        .buffer_one(buffer_one), .scan_sync(scan_sync), .cpu_clock_hold(cpu_clock_hold),
        .scan_in_done(scan_in_done), .logout_done(logout_done),
        .control_word_fetch(control_word_fetch), .dec_busy(dec_busy),
        .scan_left_word(scan_left_word), .word_sel(word_sel),
        .storage_address_bus(storage_address_bus));
    sas_storage_model u_mem (.core_clk(core_clk), .arst_n(arst_n), .scan_sync(scan_sync),
        .storage_address_bus(storage_address_bus), .last_addr(last_addr),
        .access_count(access_count));

    // Free-running 200 MHz clock
    always #2.5 core_clk = ~core_clk;
    // Hang guard
    initial begin
        #250000;
        err_total++;
        stop_test();
    end

    task chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task stop_test();
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    task tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    // One-cycle pulse: 0 store, 1 toggle, 2 clear, 3 cs start, 4 flt load, 5 flt dec
    task pulse(input int which);
        @(posedge core_clk);
        {scan_store_order, toggle_buffer_order, scan_sync_clear, cs_test_start, flt_load,
         flt_dec_req} <= 6'h20 >> which;
        @(posedge core_clk);
        {scan_store_order, toggle_buffer_order, scan_sync_clear, cs_test_start, flt_load,
         flt_dec_req} <= 6'h00;
        tick(2);
    endtask : pulse
    task preset(input sas_preset_e p);
        @(posedge core_clk) preset_order <= p;
        @(posedge core_clk) preset_order <= SAS_SET_NONE;
        tick(2);
    endtask : preset
    // Capture clears the sequencer, the next edge writes the result
    task dec_seq(input int exp);
        int n;
        n = 0;
        @(posedge core_clk) seq_dec_req <= 1'b1;
        @(posedge core_clk) seq_dec_req <= 1'b0;
        tick(1);
        while (seq_value !== 5'h00 && n < 8) begin
            tick(1);
            n++;
        end
        chk("seq_cleared", seq_value, 24'h0);
        chk("dec_busy", dec_busy, 24'h1);
        tick(1);
        chk("seq_decrement", seq_value, exp);
    endtask : dec_seq
    task wait_done(input int which);
        int n;
        n = 0;
        while ((which ? logout_done : scan_in_done) !== 1'b1 && n < 16) begin
            tick(1);
            n++;
        end
        chk("done_flag", which ? logout_done : scan_in_done, 24'h1);
    endtask : wait_done
    function automatic logic [23:0] exp_addr(input int s, input int lg, input int b);
        if (lg != 0)
            return ((s >= 16) ? 24'h000100 : 24'h000080) + 24'((s % 16) * 8);
        return ((b != 0) ? 24'h000100 : 24'h000200) + 24'(s * 8);
    endfunction : exp_addr

    initial begin
        void'($urandom(84332));
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        tick(1);
        chk("cs_reset", cs_seq_value, 24'h7);
        chk("buf_reset", buffer_one, 24'h1);
        chk("sab_reset", storage_address_bus, 24'h0);
        // Every preset order, then a random word load, through the decoder
        @(posedge core_clk) mode <= SAS_MODE_LOGIC_TEST;
        foreach (pv[i]) begin
            preset(po[i]);
            chk("preset", seq_value, pv[i]);
            chk("word_sel", word_sel, 24'h1 << pv[i]);
        end
        v = $urandom % 32;
        lw = $urandom % 2;
        @(posedge core_clk);
        {work_reg_bits, left_word_select, load_from_word} <= {5'(v), 1'(lw), 1'b1};
        @(posedge core_clk) load_from_word <= 1'b0;
        tick(2);
        chk("word_load", seq_value, v);
        chk("left_word", scan_left_word, lw);
        chk("word_sel_ld", word_sel, (v < 24) ? 24'h1 << v : 24'h0);
        @(posedge core_clk) scan_out_active <= 1'b0;
        tick(2);
        chk("word_sel_off", word_sel, 24'h0);
        @(posedge core_clk) scan_out_active <= 1'b1;
        // Scan-in from 16 to 0 with a buffer flip midway
        preset(SAS_SET_16);
        pulse(0);
        m_buf = 1;
        for (int s = 16; s > 0; s--) begin
            tick(1);
            chk("test_addr", storage_address_bus, exp_addr(s, 0, m_buf));
            chk("cw_fetch", control_word_fetch, (s == 1));
            if (s == 8) begin
                pulse(1);
                m_buf ^= 1;
                chk("buf_toggle", buffer_one, m_buf);
            end
            dec_seq(s - 1);
        end
        wait_done(0);
        pulse(2);
        chk("sync_clear", scan_sync, 24'h0);
        chk("sab_gated", storage_address_bus, 24'h0);
        // Logout: 23 down to 0, back to 23, then 7 down to 0
        @(posedge core_clk) mode <= SAS_MODE_LOGOUT;
        preset(SAS_SET_23);
        pulse(0);
        for (int s = 23; s > 0; s--) begin
            tick(1);
            chk("clock_hold", cpu_clock_hold, (s >= 14) ? 24'h1 : 24'h0);
            chk("logout_addr", storage_address_bus, exp_addr(s, 1, 0));
            dec_seq((s == 1) ? 23 : s - 1);
        end
        chk("stores_seen", last_addr, 24'h000088);
        preset(SAS_SET_7);
        for (int s = 7; s > 0; s--)
            dec_seq(s - 1);
        wait_done(1);
        pulse(2);
        // Two requests in one cycle share the path in turn
        @(posedge core_clk) mode <= SAS_MODE_CS_TEST;
        preset(SAS_SET_13);
        m_buf = buffer_one;
        @(posedge core_clk) {flt_phase, seq_dec_req} <= {2'h3, 1'b1};
        @(posedge core_clk) {flt_phase, seq_dec_req} <= {2'h0, 1'b0};
        tick(8);
        chk("cs_step", cs_seq_value, 24'h6);
        chk("seq_step", seq_value, 24'hc);
        chk("cs_sync", scan_sync, 24'h1);
        pulse(3);
        chk("cs_start", cs_seq_value, 24'h7);
        chk("cs_buf", buffer_one, m_buf ^ 1);
        // Cycle counter borrow into the sequencer
        @(posedge core_clk) mode <= SAS_MODE_COUNT;
        flt_load_val <= 4'h0;
        pulse(4);
        pulse(5);
        tick(6);
        chk("count_seq", seq_value, 24'hb);
        chk("count_flt", flt_value, 24'hf);
        stop_test();
    end
endmodule : test_scan_address_sequencer
